// [dv/fpp_fault_chk.sv]
// Purpose: port-level checks of the fault and phase block
// Assumes: sync_line seen raw here, three flops inside the block
// Notes:   line timing window allows for the pin synchroniser
`timescale 1ns/1ns
`default_nettype none
module fpp_fault_chk (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       sync_line,
  input wire logic       grp_fault_o,
  input wire logic       grp_fault_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       above_prebias,
  input wire logic       over_current,
  input wire logic       excess_output_voltage,
  input wire logic       ov_emergency,
  input wire logic       output_on,
  input wire logic       ramp_down,
  input wire logic       hs_off,
  input wire logic       ls_on,
  input var  fpp_pkg::fpp_off_t off_type
);
  import fpp_pkg::*;
  // ****************
  // helpers and checks
  // ****************
  logic       sync_q_r;
  logic [3:0] since_r;
  always_ff @(posedge sys_clk) begin
    sync_q_r <= sync_line;
  end
  // cycles since the raw sync fall, saturating so idle time never wraps
  always_ff @(posedge sys_clk) begin
    if (rst) since_r <= 4'hF;
    else if (sync_q_r && !sync_line) since_r <= 4'h0;
    else if (since_r != 4'hF) since_r <= since_r + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_line_on_sync: assert property ($changed(grp_fault_oe) |-> since_r >= 4'h2 && since_r <= 4'h8)
    else $error("group line moved away from a sync fall");
  a_line_low_only: assert property (grp_fault_o == 1'b0)
    else $error("group line driven high");
  a_ls_needs_hs: assert property (ls_on |-> hs_off)
    else $error("low side on with high side on");
  a_ls_emerg_only: assert property (ls_on |-> off_type == OFF_EMERG)
    else $error("low side on outside emergency");
  a_ramp_is_seq: assert property (ramp_down |-> off_type == OFF_SEQ)
    else $error("ramp outside sequenced turn-off");
  a_ov_fast_off: assert property ($rose(excess_output_voltage) && above_prebias && output_on
    && !ramp_down |-> ##[2:4] (hs_off && !output_on && ls_on == ov_emergency))
    else $error("over-voltage not turned off fast");
  a_oc_fast_off: assert property ($rose(over_current) && above_prebias && output_on && !ramp_down
    |-> ##[2:4] (hs_off && !ls_on && !output_on && off_type == OFF_CRIT))
    else $error("over-current not turned off critical");
  a_cfg_bit4_zero: assert property ($past(reg_addr) == ADDR_PHASE_CFG |-> !reg_rdata[4])
    else $error("config bit 4 read as one");
  a_cfg_run_lock: assert property (output_on && $past(output_on) && $past(output_on, 2)
    && $past(reg_addr) == ADDR_PHASE_CFG && $past(reg_addr, 2) == ADDR_PHASE_CFG
    |-> $stable(reg_rdata))
    else $error("config changed while running");
  c_line_drop: cover property ($rose(grp_fault_oe));
  c_emerg_off: cover property ($rose(ls_on));
  c_seq_ramp: cover property ($rose(ramp_down));
endmodule : fpp_fault_chk
bind fpp_fault_ctl fpp_fault_chk u_chk (
  .sys_clk, .rst, .sync_line, .grp_fault_o, .grp_fault_oe, .reg_addr, .reg_rdata,
  .above_prebias, .over_current, .excess_output_voltage, .ov_emergency, .output_on,
  .ramp_down, .hs_off, .ls_on, .off_type
);
`default_nettype wire

// [dv/fpp_pm_model.sv]
// Purpose: power manager and peer model on sync and group line
// Assumes: group line open drain with pull-up
// Notes:   sync runs free, phase unrelated to sys_clk
`timescale 1ns/1ns
`default_nettype none
module fpp_pm_model (
  input  wire logic       dut_oe,
  input  wire logic       send,
  input  wire logic [1:0] code,
  output var  logic       sync_line,
  output wire logic       grp_wire
);
  // ****************
  // sync and peer coding
  // ****************
  logic       pull_r;
  logic [1:0] step_r;
  initial begin
    sync_line = 1'b1;
    pull_r = 1'b0;
    step_r = 2'd0;
  end
  always begin
    #62 sync_line = 1'b0;
    #63 sync_line = 1'b1;
  end
  // peer moves the line only on the sync fall, coding passed on unchanged
  always @(negedge sync_line) begin
    if (!send) begin
      pull_r <= 1'b0;
      step_r <= 2'd0;
    end else begin
      case (step_r)
        2'd0: pull_r <= 1'b1;
        2'd1: pull_r <= !code[1];
        2'd2: pull_r <= !code[0];
        default: pull_r <= 1'b1;
      endcase
      if (step_r != 2'd3) step_r <= step_r + 2'd1;
    end
  end
  assign grp_wire = !(dut_oe || pull_r);
endmodule : fpp_pm_model
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench of the fault and phase block
// Assumes: manager model makes sync and group line
// Notes:   hiccup shortened to keep the run short
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import fpp_pkg::*;
  // ****************
  // bench
  // ****************
  localparam int HC = 2000;
  logic        sys_clk, rst, reg_wr, turn_on, above_prebias, ramp_done, heat;
  logic        ot_critical, ov_emergency, send, grp_wire, sync_line;
  logic        grp_fault_o, grp_fault_oe, output_on, ramp_down, hs_off, ls_on;
  logic [1:0]  code;
  logic [3:0]  flt, prop_en, cyc_start, latch_en;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, v;
  logic [15:0] toff_delay;
  fpp_off_t    off_type;
  int          fails, checks, d0, d8, n;
  integer      seed;
  fpp_fault_ctl #(.HICCUP_CYCLES(HC), .PW(12)) u_dut (
    .sys_clk, .rst, .sync_line, .grp_fault_i(grp_wire), .grp_fault_o, .grp_fault_oe,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .turn_on, .above_prebias,
    .over_temperature(flt[F_OT]), .over_current(flt[F_OC]), .low_output_voltage(flt[F_UV]),
    .excess_output_voltage(flt[F_OV]), .heat_warning(heat), .prop_en, .latch_en,
    .ot_critical, .ov_emergency, .toff_delay, .ramp_done, .output_on, .ramp_down,
    .hs_off, .ls_on, .off_type, .cyc_start);
  fpp_pm_model u_pm (.dut_oe(grp_fault_oe), .send, .code, .sync_line, .grp_wire);
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  function automatic logic [3:0] exp_en(input logic [1:0] p);
    exp_en = (p == 2'd0) ? 4'h1 : (p == 2'd1) ? 4'h5 : (p == 2'd2) ? 4'h7 : 4'hF;
  endfunction : exp_en
  // upper pair is the turn-off type, lower pair the line levels after the drop
  function automatic logic [3:0] exp_off(input int f);
    case (f)
      F_OV: exp_off = ov_emergency ? {OFF_EMERG, 2'b01} : {OFF_CRIT, 2'b10};
      F_OT: exp_off = ot_critical ? {OFF_CRIT, 2'b10} : {OFF_SEQ, 2'b00};
      F_OC: exp_off = {OFF_CRIT, 2'b10};
      default: exp_off = {OFF_SEQ, 2'b00};
    endcase
  endfunction : exp_off
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic guard(input int lim);
    n++;
    tick(1);
    if (n > lim) begin
      fails++;
      conclude();
    end
  endtask : guard
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmp_rng(input string nm, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi) begin
      fails++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : cmp_rng
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    tick(1);
    d = reg_rdata;
  endtask : rd
  task automatic wait_on(input logic s);
    n = 0;
    while (output_on !== s) guard(4000);
  endtask : wait_on
  // switching starts only after lock, so settle two sync periods first
  task automatic meas(output int c);
    tick(30);
    @(negedge sync_line);
    n = 0;
    tick(1);
    // the first cycles still hold starts of the period before
    while (n < 4 || cyc_start[0] !== 1'b1) guard(40);
    c = n;
  endtask : meas
  task automatic en_check(input logic [3:0] e, input int r);
    logic [3:0] acc;
    int         k;
    acc = 4'h0;
    k = 0;
    repeat (100) begin
      tick(1);
      acc = acc | cyc_start;
      k = k + int'(cyc_start[0]);
    end
    cmp("phase enables", {4'h0, e}, {4'h0, acc});
    cmp_rng("start pulses", 7 * r, 9 * r, k);
  endtask : en_check
  task automatic run_fault(input int f);
    int         t0;
    logic [3:0] e;
    logic [1:0] c;
    e = exp_off(f);
    wr(ADDR_STATUS, 8'hFF);
    prop_en = (f == F_UV) ? 4'h0 : 4'hF;
    toff_delay = 16'(8 + ($random(seed) & 31));
    t0 = $time / 10;
    flt[f] = 1'b1;
    n = 0;
    if (f == F_UV) begin
      while (ramp_down !== 1'b1) guard(200);
      flt[f] = 1'b0;
      cmp_rng("turn-off delay", toff_delay + 1, toff_delay + 4, n);
      rd(ADDR_STATUS);
      cmp("uv status", 8'h02, d & 8'h06);
      n = 0;
      repeat (300) begin
        tick(1);
        if (grp_wire !== 1'b1) n++;
      end
      cmp_rng("line lows", 0, 0, n);
    end else begin
      tick(3);
      flt[f] = 1'b0;
      get_code(c);
      cmp("off code", {6'h0, e[1:0]}, {6'h0, c});
    end
    cmp("off type", {6'h0, e[3:2]}, {6'h0, off_type});
    wait_on(1'b1);
    cmp_rng("retry gap", HC, HC + 60, $time / 10 - t0);
  endtask : run_fault
  task automatic get_code(output logic [1:0] c);
    n = 0;
    while (grp_wire !== 1'b0) guard(400);
    @(negedge sync_line);
    tick(7);
    c[1] = grp_wire;
    @(negedge sync_line);
    tick(7);
    c[0] = grp_wire;
  endtask : get_code
  initial begin
    seed = 32'h9C80;
    fails = 0;
    checks = 0;
    {rst, reg_wr, reg_addr, reg_wdata, turn_on, heat, send, code, flt, latch_en} = {1'b1, 30'h0};
    {above_prebias, ramp_done, ot_critical, ov_emergency, prop_en} = 8'hC0;
    toff_delay = 16'h0008;
    tick(2);
    rst = 1'b0;
    cmp("reset outputs", 8'h08, {1'b0, grp_fault_oe, output_on, ramp_down, hs_off, ls_on,
      off_type});
    rd(ADDR_PHASE_CFG);
    cmp("cfg reset", PHASE_CFG_RST, d);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'hFF : 8'($random(seed));
      wr(ADDR_PHASE_CFG, v);
      rd(ADDR_PHASE_CFG);
      cmp("cfg readback", v & 8'hEF, d);
    end
    rd(8'h3C);
    cmp("unmapped", 8'h00, d);
    wr(ADDR_PHASE_CFG, 8'h00);
    turn_on = 1'b1;
    wait_on(1'b1);
    meas(d0);
    en_check(exp_en(2'd0), 1);
    wr(ADDR_PHASE_CFG, 8'hC8);
    rd(ADDR_PHASE_CFG);
    cmp("cfg while running", 8'h00, d);
    code = 2'b01;
    send = 1'b1;
    wait_on(1'b0);
    tick(3);
    cmp("peer off", {4'h0, 2'b11, OFF_EMERG}, {4'h0, hs_off, ls_on, off_type});
    wr(ADDR_PHASE_CFG, 8'hE4);
    rd(ADDR_PHASE_CFG);
    cmp("cfg while off", 8'hE4, d);
    send = 1'b0;
    wait_on(1'b1);
    meas(d8);
    cmp_rng("interleave shift", 2, 4, d8 - d0);
    en_check(exp_en(2'd3), 2);
    heat = 1'b1;
    tick(200);
    cmp("on under warning", 8'h01, {7'h0, output_on});
    rd(ADDR_STATUS);
    cmp("warning status", 8'h00, d & 8'h80);
    heat = 1'b0;
    for (int i = 0; i < 8; i++) begin
      ov_emergency = 1'($random(seed));
      ot_critical = 1'($random(seed));
      run_fault(i % 4);
    end
    // a latched fault holds the block off past the hiccup until its status is cleared
    latch_en[F_OC] = 1'b1;
    flt[F_OC] = 1'b1;
    tick(3);
    flt[F_OC] = 1'b0;
    tick(HC + 100);
    cmp("latched off", 8'h00, {7'h0, output_on});
    wr(ADDR_STATUS, 8'hFF);
    wait_on(1'b1);
    cmp("retry after clear", 8'h01, {7'h0, output_on});
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// [rtl/fpp_fault_ctl.sv]
// Purpose: fault response, group line coding and switching setup of a load regulator
// Assumes: fault detect inputs come from same-clock monitor logic; sync and group line are pins
// Notes:   group line is open drain, driven only low
`timescale 1ns/1ns
`default_nettype none
module fpp_fault_ctl #(
  parameter int HICCUP_CYCLES = fpp_pkg::HICCUP_CYC,
  parameter int PW            = 12
) (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       sync_line,
  input  wire logic       grp_fault_i,
  output logic            grp_fault_o,
  output logic            grp_fault_oe,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       turn_on,
  input  wire logic       above_prebias,
  input  wire logic       over_temperature,
  input  wire logic       over_current,
  input  wire logic       low_output_voltage,
  input  wire logic       excess_output_voltage,
  input  wire logic       heat_warning,
  input  wire logic [3:0] prop_en,
  input  wire logic [3:0] latch_en,
  input  wire logic       ot_critical,
  input  wire logic       ov_emergency,
  input  wire logic [15:0] toff_delay,
  input  wire logic       ramp_done,
  output logic            output_on,
  output logic            ramp_down,
  output logic            hs_off,
  output logic            ls_on,
  output var fpp_pkg::fpp_off_t off_type,
  output logic [3:0]      cyc_start
);
  import fpp_pkg::*;

  initial begin
    if (HICCUP_CYCLES < 2 || HICCUP_CYCLES >= 2**24) $error("fpp_fault_ctl: bad HICCUP_CYCLES");
  end

  // ****************************************
  // pin sampling and phase generator
  // ****************************************
  logic [1:0] lvl, fall;
  logic       sync_fall, grp_lvl;

  fpp_pin_sync #(.W(2)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     ({grp_fault_i, sync_line}),
    .level   (lvl),
    .fall    (fall)
  );
  assign sync_fall = fall[0];
  assign grp_lvl   = lvl[1];

  fpp_swp_if sw ();

  fpp_phase_gen #(.PW(PW)) u_gen (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sw      (sw)
  );

  // ****************************************
  // switching phase configuration
  // ****************************************
  fpp_state_t state_r;
  logic [7:0] pcfg_r;
  logic [4:0] st_r;                                        // tw, ot, oc, uv, ov
  logic       running;

  assign running = (state_r != S_OFF) && (state_r != S_HALT);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pcfg_r <= PHASE_CFG_RST;
    end else if (reg_wr && reg_addr == ADDR_PHASE_CFG && !running) begin
      pcfg_r <= reg_wdata & 8'hEF;
    end
  end

  assign sw.sync_fall  = sync_fall;
  assign sw.interleave = pcfg_r[PCFG_INT_LSB +: 4];
  assign sw.rate_fast  = pcfg_r[PCFG_RATE_BIT];
  assign sw.phase_cnt  = pcfg_r[PCFG_PHS_LSB +: 2];
  assign sw.run        = (state_r == S_RUN);
  assign cyc_start     = sw.cyc_start;

  // status reads active-low per fault, unused bits high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr == ADDR_PHASE_CFG) begin
      reg_rdata <= pcfg_r & 8'hEF;
    end else if (reg_addr == ADDR_STATUS) begin
      reg_rdata <= {~st_r[4], 2'h3, ~st_r[3:0], 1'b1};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // fault classification
  // ****************************************
  logic [3:0] f_act;
  logic       own_trip, own_prop;
  fpp_off_t   own_type;

  always_comb begin
    f_act[F_OT] = over_temperature;
    f_act[F_OC] = over_current && above_prebias;
    f_act[F_OV] = excess_output_voltage && above_prebias;
    f_act[F_UV] = low_output_voltage && state_r == S_RUN;
    own_trip = (state_r == S_RUN) && (|f_act);
    own_prop = |(f_act & prop_en);
    if (f_act[F_OV]) begin
      own_type = ov_emergency ? OFF_EMERG : OFF_CRIT;
    end else if (f_act[F_OC]) begin
      own_type = OFF_CRIT;
    end else if (f_act[F_OT]) begin
      own_type = ot_critical ? OFF_CRIT : OFF_SEQ;
    end else begin
      own_type = OFF_SEQ;
    end
  end

  // set wins over a clear written in the same cycle
  logic [4:0] st_set, st_clr;
  assign st_set = {heat_warning, f_act[F_OT], f_act[F_OC], f_act[F_UV], f_act[F_OV]};
  assign st_clr = (reg_wr && reg_addr == ADDR_STATUS) ?
                  {reg_wdata[ST_TW_BIT], reg_wdata[ST_OT_BIT], reg_wdata[ST_OC_BIT],
                   reg_wdata[ST_UV_BIT], reg_wdata[ST_OV_BIT]} : 5'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= (st_r & ~st_clr) | st_set;
    end
  end

  logic latched;
  assign latched = |(st_r[3:0] & latch_en);

  // ****************************************
  // group line receive
  // ****************************************
  logic [1:0] rx_stage_r;
  logic       rx_b1_r, rx_prev_r, ext_trip_r, tx_busy;
  fpp_off_t   ext_type_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_stage_r <= '0;
      rx_b1_r    <= 1'b0;
      rx_prev_r  <= 1'b1;
      ext_trip_r <= 1'b0;
      ext_type_r <= OFF_SEQ;
    end else begin
      ext_trip_r <= 1'b0;
      if (sync_fall) begin
        rx_prev_r <= grp_lvl;
        if (tx_busy) begin
          rx_stage_r <= '0;
        end else if (rx_stage_r == 2'd0 && rx_prev_r && !grp_lvl) begin
          rx_stage_r <= 2'd1;
        end else if (rx_stage_r == 2'd1) begin
          rx_b1_r    <= grp_lvl;
          rx_stage_r <= 2'd2;
        end else if (rx_stage_r == 2'd2) begin
          rx_stage_r <= '0;
          ext_trip_r <= 1'b1;
          case ({rx_b1_r, grp_lvl})
            PAT_CRIT:  ext_type_r <= OFF_CRIT;
            PAT_EMERG: ext_type_r <= OFF_EMERG;
            default:   ext_type_r <= OFF_SEQ;
          endcase
        end
      end
    end
  end

  // ****************************************
  // group line transmit
  // ****************************************
  logic       tx_req_r, tx_rel_r;
  logic [1:0] tx_stage_r, tx_pat_r;

  assign tx_busy = tx_req_r || tx_stage_r != 2'd0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      grp_fault_o  <= 1'b0;
      grp_fault_oe <= 1'b0;
      tx_stage_r   <= '0;
    end else if (sync_fall) begin
      case (tx_stage_r)
        2'd0: if (tx_req_r) begin
          grp_fault_oe <= 1'b1;
          tx_stage_r   <= 2'd1;
        end
        2'd1: begin
          grp_fault_oe <= ~tx_pat_r[1];
          tx_stage_r   <= 2'd2;
        end
        2'd2: begin
          grp_fault_oe <= ~tx_pat_r[0];
          tx_stage_r   <= 2'd3;
        end
        default: begin
          grp_fault_oe <= ~tx_rel_r;
          if (tx_rel_r) tx_stage_r <= 2'd0;
        end
      endcase
    end
  end

  // ****************************************
  // turn-off sequencer
  // ****************************************
  logic [15:0] dly_r;
  logic [23:0] hic_r;
  logic        tripped_r, hic_done;

  assign hic_done = (hic_r == '0);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r   <= S_OFF;
      dly_r     <= '0;
      tripped_r <= 1'b0;
      off_type  <= OFF_SEQ;
      tx_req_r  <= 1'b0;
      tx_pat_r  <= PAT_SEQ;
      tx_rel_r  <= 1'b0;
    end else begin
      if (sync_fall && tx_stage_r == 2'd0) tx_req_r <= 1'b0;
      if (sync_fall && tx_stage_r == 2'd3 && tx_rel_r) tx_rel_r <= 1'b0;
      case (state_r)
        S_OFF: begin
          if (turn_on && !latched && grp_lvl) begin
            state_r   <= S_RUN;
            tripped_r <= 1'b0;
          end
        end
        S_RUN: begin
          if (own_trip || ext_trip_r) begin
            tripped_r <= 1'b1;
            off_type  <= own_trip ? own_type : ext_type_r;
            if (own_trip && own_prop) begin
              tx_req_r <= 1'b1;
              tx_pat_r <= off_pattern(own_type);
            end
            if ((own_trip ? own_type : ext_type_r) == OFF_SEQ) begin
              state_r <= S_DELAY;
              dly_r   <= toff_delay;
            end else begin
              state_r <= S_HALT;
            end
          end else if (!turn_on) begin
            state_r  <= S_DELAY;
            off_type <= OFF_SEQ;
            dly_r    <= toff_delay;
          end
        end
        S_DELAY: begin
          if (dly_r == '0) state_r <= S_RAMP;
          else dly_r <= dly_r - 16'h0001;
        end
        S_RAMP: begin
          if (ramp_done) state_r <= tripped_r ? S_HALT : S_OFF;
        end
        default: begin
          // retry waits on the line being free, so a peer still low holds us off
          if (hic_done && !latched) begin
            if (tx_stage_r != 2'd0) begin
              tx_rel_r <= 1'b1;
            end else if (grp_lvl && !tx_req_r) begin
              state_r <= turn_on ? S_RUN : S_OFF;
              tripped_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // timer runs from the trip, so the turn-off delay eats into it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hic_r <= '0;
    end else if (state_r == S_RUN && (own_trip || ext_trip_r)) begin
      hic_r <= 24'(HICCUP_CYCLES - 1);
    end else if (!hic_done) begin
      hic_r <= hic_r - 24'h000001;
    end
  end

  // ****************************************
  // power stage outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      output_on <= 1'b0;
      ramp_down <= 1'b0;
      hs_off    <= 1'b1;
      ls_on     <= 1'b0;
    end else begin
      output_on <= running;
      ramp_down <= (state_r == S_RAMP);
      hs_off    <= !(state_r == S_RUN || state_r == S_DELAY || state_r == S_RAMP);
      ls_on     <= (state_r == S_HALT) && (off_type == OFF_EMERG);
    end
  end
endmodule : fpp_fault_ctl
`default_nettype wire

// [rtl/fpp_phase_gen.sv]
// Purpose: locks switching cycle starts to the sync fall with interleave delay
// Assumes: sync period below 2**PW sys_clk cycles
// Notes:   period is re-measured every sync fall, so a drifting master is followed
`timescale 1ns/1ns
`default_nettype none
module fpp_phase_gen #(
  parameter int PW = 12
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  fpp_swp_if.gen    sw
);
  import fpp_pkg::*;

  initial begin
    if (PW < 6 || PW > 16) $error("fpp_phase_gen: PW out of range");
  end

  logic [PW-1:0]   cnt_r, per_r;
  logic [PW+3:0]   prod;
  logic [PW-1:0]   dly, half, dly2;
  logic            hit;

  // measured sync period in sys_clk cycles
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_r     <= '0;
      per_r     <= '0;
      sw.locked <= 1'b0;
    end else if (sw.sync_fall) begin
      cnt_r     <= '0;
      per_r     <= cnt_r + 1'b1;
      sw.locked <= 1'b1;
    end else if (cnt_r != '1) begin
      cnt_r <= cnt_r + 1'b1;
    end else begin
      sw.locked <= 1'b0;
    end
  end

  always_comb begin
    prod = per_r * sw.interleave;
    dly  = prod[PW+3:4];
    half = per_r >> 1;
    dly2 = (dly >= half) ? PW'(dly - half) : PW'(dly + half);
    hit  = (cnt_r == dly) || (sw.rate_fast && cnt_r == dly2);
  end

  // starts referenced to the sync fall, so only a locked run emits them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw.cyc_start <= '0;
    end else if (sw.run && sw.locked && hit) begin
      sw.cyc_start <= phase_enables(sw.phase_cnt);
    end else begin
      sw.cyc_start <= '0;
    end
  end
endmodule : fpp_phase_gen
`default_nettype wire

// [rtl/fpp_pin_sync.sv]
// Purpose: three-stage pin synchroniser with agreement filter and fall pulse
// Assumes: pins are asynchronous to sys_clk
// Notes:   stage one feeds only stage two
`timescale 1ns/1ns
`default_nettype none
module fpp_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_r, s2_r, s3_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        level[i] <= 1'b1;
        fall[i]  <= 1'b0;
      end else begin
        fall[i] <= 1'b0;
        if (s2_r[i] == s3_r[i] && s3_r[i] != level[i]) begin
          level[i] <= s3_r[i];
          fall[i]  <= ~s3_r[i];
        end
      end
    end
  end
endmodule : fpp_pin_sync
`default_nettype wire

// [rtl/fpp_pkg.sv]
// Purpose: shared constants and types of the fault and phase block
// Assumes: sys_clk at 100 MHz
// Notes:   turn-off patterns are the line levels sampled at the two sync falls after the drop
package fpp_pkg;
  localparam int          CLK_MHZ         = 100;
  localparam int          HICCUP_MS       = 130;
  localparam int          HICCUP_CYC      = HICCUP_MS * 1000 * CLK_MHZ;
  localparam logic [7:0]  ADDR_PHASE_CFG  = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h16;
  localparam logic [7:0]  PHASE_CFG_RST   = 8'h00;
  localparam int          PCFG_INT_LSB    = 0;
  localparam int          PCFG_RATE_BIT   = 5;
  localparam int          PCFG_PHS_LSB    = 6;
  localparam int          ST_TW_BIT       = 7;
  localparam int          ST_OT_BIT       = 4;
  localparam int          ST_OC_BIT       = 3;
  localparam int          ST_UV_BIT       = 2;
  localparam int          ST_OV_BIT       = 1;
  // fault index inside 4-bit masks
  localparam int          F_OT            = 3;
  localparam int          F_OC            = 2;
  localparam int          F_UV            = 1;
  localparam int          F_OV            = 0;
  localparam logic [1:0]  PAT_SEQ         = 2'h0;
  localparam logic [1:0]  PAT_CRIT        = 2'h2;
  localparam logic [1:0]  PAT_EMERG       = 2'h1;

  typedef enum logic [1:0] {
    OFF_SEQ   = 2'b00,
    OFF_CRIT  = 2'b01,
    OFF_EMERG = 2'b10
  } fpp_off_t;

  typedef enum logic [2:0] {
    S_OFF   = 3'b000,
    S_RUN   = 3'b001,
    S_DELAY = 3'b010,
    S_RAMP  = 3'b011,
    S_HALT  = 3'b100
  } fpp_state_t;

  function automatic logic [3:0] phase_enables(input logic [1:0] cnt);
    case (cnt)
      2'd0:    phase_enables = 4'h1;
      2'd1:    phase_enables = 4'h5;
      2'd2:    phase_enables = 4'h7;
      default: phase_enables = 4'hF;
    endcase
  endfunction : phase_enables

  function automatic logic [1:0] off_pattern(input fpp_off_t t);
    case (t)
      OFF_CRIT:  off_pattern = PAT_CRIT;
      OFF_EMERG: off_pattern = PAT_EMERG;
      default:   off_pattern = PAT_SEQ;
    endcase
  endfunction : off_pattern
endpackage : fpp_pkg

// [rtl/fpp_swp_if.sv]
// Purpose: carries switching setup and cycle starts between control and phase generator
// Assumes: one clock domain
// Notes:   ctl drives the setup, gen answers with starts
`timescale 1ns/1ns
`default_nettype none
interface fpp_swp_if;
  logic       sync_fall;
  logic       run;
  logic [3:0] interleave;
  logic       rate_fast;
  logic [1:0] phase_cnt;
  logic [3:0] cyc_start;
  logic       locked;
  modport ctl (output sync_fall, run, interleave, rate_fast, phase_cnt,
               input cyc_start, locked);
  modport gen (input sync_fall, run, interleave, rate_fast, phase_cnt,
               output cyc_start, locked);
endinterface : fpp_swp_if
`default_nettype wire
